// ==== rtl/pmu_system_and_conv1_regs.sv ====
// Operation
// (RL1) Reset-timer select bit picks reset timeout.
// (RL2) Drop response: interrupt if 1, shutdown if 0.
// (RL3) Supply interrupt enable resets off, 1 enables.
// (RL4) Below flag reads supply under threshold.
// (RL5) Four-bit supply threshold code, read/write.
// (RL6) Global-off command turns all regulators off.
// (RL7) Button press clears the global-off command.
// (RL8) Four spare_store_bits bits, cleared on system shutdown.
// (RL9) Primary voltage code applies while select low.
// (RL10) Secondary voltage code applies while select high.
// (RL11) Control bit 7 enables converter one.
// (RL12) Phase bit selects 180 degree switching.
// (RL13) Mode bit forces fixed-frequency PWM.
// (RL14) Three-bit turn-on delay field.
// (RL15) Fault interrupt enable bit gates faults.
// (RL16) Control bit 0 reads power-good.
// (RL17) Power-loss reset returns all bits to default.
// (RL18) Reserved bits read zero, ignore writes.
`include "pmu_regs_defines.svh"

module pmu_system_and_conv1_regs
  import pmu_regs_pkg::*;
#(
  parameter logic [6:0] dev_addr = 7'h5B  // Arbitrary bus address.
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       pushbutton_n_in,
  input  wire logic       voltage_select_pin_in,
  input  wire logic       supply_below_in,
  input  wire logic       power_good_in,
  output logic            reset_timer_sel_out,
  output logic [3:0]      supply_threshold_code_out,
  output logic            supply_irq_out,
  output logic            supply_shutdown_out,
  output logic            regs_all_off_out,
  output logic [5:0]      conv1_voltage_code_out,
  output logic            conv1_enable_out,
  output logic            conv1_phase_out,
  output logic            conv1_pwm_out,
  output logic [2:0]      conv1_delay_out,
  output logic            conv1_fault_irq_enable_out
);

  // ========================================================================
  // Pin synchronisers: three stages, a change counts when two and three agree.
  localparam int            NP         = 6;
  localparam logic [NP-1:0] PIN_IDLE_V = `PIN_IDLE;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1;
  logic [NP-1:0] s2;
  logic [NP-1:0] s3;
  logic [NP-1:0] filt;
  logic [NP-1:0] next_filt;
  assign pin_raw = {scl_in, sda_in, pushbutton_n_in, voltage_select_pin_in,
                    supply_below_in, power_good_in};
  for (genvar i = 0; i < NP; i++) begin : g_sync
    // Filtered level follows only an agreed pair of late stages.
    always_comb begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
    // Stage registers; reset parks every stage at the idle level of its pin.
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        {s1[i], s2[i], s3[i], filt[i]} <= {4{PIN_IDLE_V[i]}};
      end else begin
        s1[i]   <= pin_raw[i];
        s2[i]   <= s1[i];
        s3[i]   <= s2[i];
        filt[i] <= next_filt[i];
      end
    end
  end
  // Filtered pins by name; the button is active low at its pin.
  wire logic scl_f   = filt[5];
  wire logic sda_f   = filt[4];
  wire logic pb_f    = ~filt[3];
  wire logic voltage_select_pin_f  = filt[2];
  wire logic below_f = filt[1];
  wire logic pgood_f = filt[0];

  // ========================================================================
  // Register storage and read mux.
  logic [7:0] supply_mon;
  logic [7:0] master;
  logic [7:0] v_primary;
  logic [7:0] v_secondary;
  logic [7:0] c1_ctl;
  logic [5:0] vcode;
  logic [7:0] ptr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  // Reserved bits are never stored, so the mux shows them as zero.
  always_comb begin
    case (ptr)
      `OFS_SUPPLY_MON:   rd_data = supply_mon | ({7'h00, below_f} << `BIT_BELOW);  // RL4
      `OFS_MASTER:       rd_data = master;
      `OFS_C1_PRIMARY:   rd_data = v_primary;
      `OFS_C1_SECONDARY: rd_data = v_secondary;
      `OFS_C1_CONTROL:   rd_data = c1_ctl | {7'h00, pgood_f};  // RL16
      default:           rd_data = 8'h00;  // RL18
    endcase
  end

  // ========================================================================
  // Serial slave: address, pointer, then data bytes; the pointer auto-increments.
  serial_state_e state;
  serial_state_e next_state;
  logic [3:0]    cnt;
  logic [3:0]    next_cnt;
  logic [7:0]    shreg;
  logic [7:0]    next_shreg;
  logic [7:0]    tx;
  logic [7:0]    next_tx;
  logic [7:0]    next_ptr;
  logic          rw;
  logic          next_rw;
  logic          sda_low;
  logic          next_sda_low;
  logic          scl_d;
  logic          sda_d;
  logic          scl_rise;
  logic          scl_fall;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign wr_data  = shreg;
  // Next-state logic of the serial slave.
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_tx      = tx;
    next_ptr     = ptr;
    next_rw      = rw;
    next_sda_low = sda_low;
    wr_en        = 1'b0;
    if (scl_f && sda_d && !sda_f) begin
      next_state   = st_addr;
      next_cnt     = 4'h0;
      next_sda_low = 1'b0;
    end else if (scl_f && !sda_d && sda_f) begin
      next_state   = st_idle;
      next_sda_low = 1'b0;
    end else if (scl_rise) begin
      next_shreg = {shreg[6:0], sda_f};
      next_cnt   = cnt + 4'h1;
      if (state == st_rack && sda_f) begin
        next_state = st_idle;  // Master ended the read with a not-acknowledge.
      end
    end else if (scl_fall) begin
      case (state)
        st_addr: begin
          if (cnt == 4'h8) begin
            if (shreg[7:1] == dev_addr) begin
              next_state   = st_addr_ack;
              next_rw      = shreg[0];
              next_sda_low = 1'b1;
            end else begin
              next_state = st_idle;
            end
          end
        end
        st_addr_ack, st_rack: begin
          next_cnt = 4'h0;
          if (rw) begin
            next_state   = st_rdata;
            next_tx      = rd_data;
            next_sda_low = ~rd_data[7];
          end else begin
            next_state   = st_ptr;
            next_sda_low = 1'b0;
          end
        end
        st_ptr: begin
          if (cnt == 4'h8) begin
            next_state   = st_ptr_ack;
            next_ptr     = shreg;
            next_sda_low = 1'b1;
          end
        end
        st_ptr_ack, st_wack: begin
          next_state   = st_wdata;
          next_cnt     = 4'h0;
          next_sda_low = 1'b0;
          next_ptr     = (state == st_wack) ? ptr + 8'h01 : ptr;
        end
        st_wdata: begin
          if (cnt == 4'h8) begin
            next_state   = st_wack;
            next_sda_low = 1'b1;
            wr_en        = 1'b1;
          end
        end
        st_rdata: begin
          if (cnt == 4'h8) begin
            next_state   = st_rack;
            next_sda_low = 1'b0;
            next_ptr     = ptr + 8'h01;
          end else begin
            next_tx      = {tx[6:0], 1'b0};
            next_sda_low = ~tx[6];
          end
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
  end
  // Serial slave registers.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state   <= st_idle;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      sda_low <= 1'b0;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      shreg   <= next_shreg;
      tx      <= next_tx;
      ptr     <= next_ptr;
      rw      <= next_rw;
      sda_low <= next_sda_low;
      scl_d   <= scl_f;
      sda_d   <= sda_f;
    end
  end
  // Open-drain data line: drives low only, enable low while driving.
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~sda_low;

  // ========================================================================
  // Register updates.
  logic [7:0] next_supply_mon;
  logic [7:0] next_master;
  logic [7:0] next_v_primary;
  logic [7:0] next_v_secondary;
  logic [7:0] next_c1_ctl;
  logic [5:0] next_vcode;
  // Writes, hardware clears and the applied voltage code.
  always_comb begin
    next_supply_mon  = supply_mon;
    next_master      = master;
    next_v_primary   = v_primary;
    next_v_secondary = v_secondary;
    next_c1_ctl      = c1_ctl;
    if (wr_en) begin
      case (ptr)
        `OFS_SUPPLY_MON:   next_supply_mon  = wr_data & `WMASK_SUPPLY_MON;  // RL5
        `OFS_MASTER:       next_master      = wr_data & `WMASK_MASTER;  // RL18
        `OFS_C1_PRIMARY:   next_v_primary   = wr_data & `WMASK_VCODE;
        `OFS_C1_SECONDARY: next_v_secondary = wr_data & `WMASK_VCODE;
        `OFS_C1_CONTROL:   next_c1_ctl      = wr_data & `WMASK_C1_CONTROL;
        default:           next_c1_ctl      = c1_ctl;
      endcase
    end
    if (supply_shutdown_out) begin
      next_master[3:0] = 4'h0;  // RL8
    end
    if (pb_f) begin
      next_master[`BIT_GLOBAL_OFF] = 1'b0;  // RL7
    end
    next_vcode = voltage_select_pin_f ? v_secondary[5:0] : v_primary[5:0];  // RL9
  end
  // Register bank flops; the reset stands for loss of input power.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      supply_mon  <= `RST_SUPPLY_MON;  // RL17
      master      <= `RST_MASTER;
      v_primary   <= `RST_C1_PRIMARY;
      v_secondary <= `RST_C1_SECONDARY;
      c1_ctl      <= `RST_C1_CONTROL;
      vcode       <= 6'h00;
    end else begin
      supply_mon  <= next_supply_mon;
      master      <= next_master;
      v_primary   <= next_v_primary;
      v_secondary <= next_v_secondary;
      c1_ctl      <= next_c1_ctl;
      vcode       <= next_vcode;  // RL10
    end
  end

  // ========================================================================
  // Control outputs.
  assign reset_timer_sel_out       = supply_mon[`BIT_RST_TIMER];  // RL1
  assign supply_threshold_code_out = supply_mon[3:0];  // RL5
  assign supply_irq_out            = below_f & supply_mon[`BIT_DROP_RESP]
                                     & supply_mon[`BIT_DROP_IRQ_EN];  // RL3
  assign supply_shutdown_out       = below_f & ~supply_mon[`BIT_DROP_RESP];  // RL2
  assign regs_all_off_out          = master[`BIT_GLOBAL_OFF];  // RL6
  assign conv1_voltage_code_out    = vcode;
  assign conv1_enable_out          = c1_ctl[`BIT_C1_ON] & ~regs_all_off_out
                                     & ~supply_shutdown_out;  // RL11
  assign conv1_phase_out           = c1_ctl[`BIT_C1_PHASE];  // RL12
  assign conv1_pwm_out             = c1_ctl[`BIT_C1_PWM];  // RL13
  assign conv1_delay_out           = c1_ctl[4:2];  // RL14
  assign conv1_fault_irq_enable_out = c1_ctl[`BIT_C1_FLT_EN];  // RL15

  // ========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  chk_primary_code_apply: assert property (!$past(voltage_select_pin_f) && !$past(rst_in) |-> // RL9
    conv1_voltage_code_out == $past(v_primary[5:0])) else $error("Primary code not applied.");
  chk_secondary_code_apply: assert property ($past(voltage_select_pin_f) && !$past(rst_in) |-> // RL10
    conv1_voltage_code_out == $past(v_secondary[5:0])) else $error("Secondary code wrong.");
  chk_button_clears_off: assert property (pb_f |=> !regs_all_off_out) // RL7
    else $error("Global off survived button press.");
  chk_off_write_sets: assert property (wr_en && ptr == `OFS_MASTER && wr_data[5] && !pb_f // RL6
    |=> regs_all_off_out && !conv1_enable_out) else $error("Global off not taken.");
  chk_drop_shutdown: assert property (below_f && !supply_mon[6] |-> supply_shutdown_out // RL2
    && !supply_irq_out) else $error("Supply drop response wrong.");
  chk_irq_needs_enable: assert property (supply_irq_out |-> supply_mon[5]) // RL3
    else $error("Supply interrupt without enable.");
  chk_reserved_zero: assert property (ptr == `OFS_MASTER |-> rd_data[7:6] == 2'b00 // RL18
    && rd_data[4] == 1'b0) else $error("Reserved bit read nonzero.");
  chk_pgood_reads: assert property (ptr == `OFS_C1_CONTROL |-> rd_data[0] == pgood_f) // RL16
    else $error("Power-good bit mismatch.");
  chk_reset_default: assert property ($past(rst_in) |-> c1_ctl == `RST_C1_CONTROL // RL17
    && master == `RST_MASTER) else $error("Register not at default after reset.");
endmodule : pmu_system_and_conv1_regs

// ==== rtl/pmu_regs_defines.svh ====
`ifndef PMU_REGS_DEFINES_SVH
`define PMU_REGS_DEFINES_SVH

// ==========================================================================
// Register offsets.
`define OFS_SUPPLY_MON   8'h00
`define OFS_MASTER       8'h01
`define OFS_C1_PRIMARY   8'h20
`define OFS_C1_SECONDARY 8'h21
`define OFS_C1_CONTROL   8'h22

// ==========================================================================
// Writable bit masks; reserved and read-only positions are zero.
`define WMASK_SUPPLY_MON 8'hEF
`define WMASK_MASTER     8'h2F
`define WMASK_VCODE      8'h3F
`define WMASK_C1_CONTROL 8'hFE

// ==========================================================================
// Field positions.
`define BIT_RST_TIMER    7
`define BIT_DROP_RESP    6
`define BIT_DROP_IRQ_EN  5
`define BIT_BELOW        4
`define BIT_GLOBAL_OFF   5
`define BIT_C1_ON        7
`define BIT_C1_PHASE     6
`define BIT_C1_PWM       5
`define BIT_C1_FLT_EN    1
`define BIT_C1_PGOOD     0

// ==========================================================================
// Reset values.
`define RST_SUPPLY_MON   8'h00
`define RST_MASTER       8'h00
`define RST_C1_PRIMARY   8'h00
`define RST_C1_SECONDARY 8'h00
`define RST_C1_CONTROL   8'h00

// Idle levels of the synchronised pins: scl, sda, button, select, below, good.
`define PIN_IDLE         6'h38

`endif

// ==== rtl/pmu_regs_pkg.sv ====
// ==========================================================================
// Types shared by the register bank.
package pmu_regs_pkg;

  // States of the two-wire serial slave.
  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_ptr,
    st_ptr_ack,
    st_wdata,
    st_wack,
    st_rdata,
    st_rack
  } serial_state_e;

endpackage : pmu_regs_pkg

// ==== tb/two_wire_host_model.sv ====
// ==========================================================================
// Host on the two-wire serial bus; SDA is released high by the pull-up.
module two_wire_host_model (
  input  wire logic sys_clk_in,
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus idles with both lines released.
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Every change is made just after a clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick

  // A start condition that also serves as a repeated start.
  task automatic start_cond();
    sda_low_out <= 1'b0;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    sda_low_out <= 1'b1;
    tick(10);
    scl_out <= 1'b0;
    tick(5);
  endtask : start_cond

  // A stop condition leaves the bus released.
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    sda_low_out <= 1'b0;
    tick(10);
  endtask : stop_cond

  // One bit: data set mid-low, sampled mid-high; both phases last 10 clocks.
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= ~b;
    tick(5);
    scl_out <= 1'b1;
    tick(5);
    r = sda_wire_in;
    tick(5);
    scl_out <= 1'b0;
    tick(5);
  endtask : bit_io

  // Sends a byte, most significant bit first, and reports the acknowledge.
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_out

  // Receives a byte, then acknowledges it or not.
  task automatic byte_in(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask : byte_in

  // Register write: address, pointer, one data byte.
  task automatic reg_write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic k1, k2, k3;
    start_cond();
    byte_out({a, 1'b0}, k1);
    byte_out(p, k2);
    byte_out(d, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask : reg_write

  // Register read: pointer set, repeated start, one byte ended by a refusal.
  task automatic reg_read(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic k1, k2, k3;
    start_cond();
    byte_out({a, 1'b0}, k1);
    byte_out(p, k2);
    start_cond();
    byte_out({a, 1'b1}, k3);
    byte_in(1'b0, d);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask : reg_read

endmodule : two_wire_host_model

// ==== tb/tb_pmu_system_and_conv1_regs.sv ====
`include "pmu_regs_defines.svh"

// ==========================================================================
// Register bank bench driven through the serial host model.
module tb_pmu_system_and_conv1_regs
  import pmu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [6:0] DEV   = 7'h5B;
  localparam int         LIMIT = 60000;

  logic       sys_clk_in, rst_in, pushbutton_n_in, voltage_select_pin_in;
  logic       supply_below_in, power_good_in, scl, host_low, sda_out, sda_oe_n_out;
  logic       reset_timer_sel_out, supply_irq_out, supply_shutdown_out, regs_all_off_out;
  logic       conv1_enable_out, conv1_phase_out, conv1_pwm_out, conv1_fault_irq_enable_out;
  logic [3:0] supply_threshold_code_out;
  logic [5:0] conv1_voltage_code_out;
  logic [2:0] conv1_delay_out;
  logic       ok;
  logic [7:0] v;
  wire  logic sda_wire;
  wire  logic [7:0] flags;
  int         miscompares, n_compared, cycles;

  // The wire is low when either party pulls it, else the pull-up wins.
  assign sda_wire = (host_low | (~sda_oe_n_out & ~sda_out)) ? 1'b0 : 1'b1;
  assign flags = {reset_timer_sel_out, supply_irq_out, supply_shutdown_out, regs_all_off_out,
                  conv1_enable_out, conv1_phase_out, conv1_pwm_out, conv1_fault_irq_enable_out};

  pmu_system_and_conv1_regs #(.dev_addr(DEV)) u_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .pushbutton_n_in(pushbutton_n_in),
    .voltage_select_pin_in(voltage_select_pin_in), .supply_below_in(supply_below_in),
    .power_good_in(power_good_in), .reset_timer_sel_out(reset_timer_sel_out),
    .supply_threshold_code_out(supply_threshold_code_out), .supply_irq_out(supply_irq_out),
    .supply_shutdown_out(supply_shutdown_out), .regs_all_off_out(regs_all_off_out),
    .conv1_voltage_code_out(conv1_voltage_code_out), .conv1_enable_out(conv1_enable_out),
    .conv1_phase_out(conv1_phase_out), .conv1_pwm_out(conv1_pwm_out),
    .conv1_delay_out(conv1_delay_out),
    .conv1_fault_irq_enable_out(conv1_fault_irq_enable_out));

  two_wire_host_model u_host (
    .sys_clk_in(sys_clk_in), .sda_wire_in(sda_wire), .scl_out(scl), .sda_low_out(host_low));

  // The 40 MHz clock.
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Compares one byte-wide result.
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : pause

  // Register access tasks; each transfer must be acknowledged.
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.reg_write(DEV, p, d, ok);
    cmp("write ack", 8'h01, {7'h00, ok});
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    u_host.reg_read(DEV, p, v, ok);
    cmp("read ack", 8'h01, {7'h00, ok});
    cmp($sformatf("register %h", p), exp, v);
  endtask : rd

  // A hung run is cut short and failed.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  // ========================================================================
  // Main sequence.
  initial begin
    rst_in = 1'b1;
    pushbutton_n_in = 1'b1;
    voltage_select_pin_in = 1'b0;
    supply_below_in = 1'b0;
    power_good_in = 1'b0;
    pause(3);
    rst_in <= 1'b0;
    pause(8);
    rd(`OFS_SUPPLY_MON, 8'h00);
    rd(`OFS_MASTER, 8'h00);
    rd(`OFS_C1_PRIMARY, 8'h00);
    rd(`OFS_C1_SECONDARY, 8'h00);
    rd(`OFS_C1_CONTROL, 8'h00);
    cmp("flags", 8'h00, flags);
    // Supply monitor: threshold, status, interrupt and its enable.
    wr(`OFS_SUPPLY_MON, 8'hFF);
    rd(`OFS_SUPPLY_MON, 8'hEF);
    cmp("threshold", 8'h0F, {4'h0, supply_threshold_code_out});
    cmp("flags", 8'h80, flags);
    supply_below_in <= 1'b1;
    pause(8);
    rd(`OFS_SUPPLY_MON, 8'hFF);
    cmp("flags", 8'hC0, flags);
    wr(`OFS_SUPPLY_MON, 8'hC5);
    rd(`OFS_SUPPLY_MON, 8'hD5);
    cmp("flags", 8'h80, flags);
    cmp("threshold", 8'h05, {4'h0, supply_threshold_code_out});
    supply_below_in <= 1'b0;
    pause(8);
    rd(`OFS_SUPPLY_MON, 8'hC5);
    // Global off, spare_store_bits bits and the push-button clear.
    wr(`OFS_MASTER, 8'hFF);
    rd(`OFS_MASTER, 8'h2F);
    cmp("flags", 8'h90, flags);
    pushbutton_n_in <= 1'b0;
    pause(8);
    pushbutton_n_in <= 1'b1;
    pause(8);
    rd(`OFS_MASTER, 8'h0F);
    cmp("flags", 8'h80, flags);
    // Converter one voltage codes and the select pin.
    wr(`OFS_C1_PRIMARY, 8'hFF);
    rd(`OFS_C1_PRIMARY, 8'h3F);
    wr(`OFS_C1_SECONDARY, 8'h2A);
    rd(`OFS_C1_SECONDARY, 8'h2A);
    cmp("voltage code", 8'h3F, {2'b00, conv1_voltage_code_out});
    voltage_select_pin_in <= 1'b1;
    pause(8);
    cmp("voltage code", 8'h2A, {2'b00, conv1_voltage_code_out});
    voltage_select_pin_in <= 1'b0;
    pause(8);
    cmp("voltage code", 8'h3F, {2'b00, conv1_voltage_code_out});
    // Converter one control fields and power-good.
    power_good_in <= 1'b1;
    wr(`OFS_C1_CONTROL, 8'hFF);
    rd(`OFS_C1_CONTROL, 8'hFF);
    cmp("flags", 8'h8F, flags);
    cmp("delay", 8'h07, {5'h00, conv1_delay_out});
    power_good_in <= 1'b0;
    wr(`OFS_C1_CONTROL, 8'h15);
    rd(`OFS_C1_CONTROL, 8'h14);
    cmp("flags", 8'h80, flags);
    cmp("delay", 8'h05, {5'h00, conv1_delay_out});
    wr(`OFS_C1_CONTROL, 8'h80);
    cmp("flags", 8'h88, flags);
    wr(`OFS_MASTER, 8'h20);
    cmp("flags", 8'h90, flags);
    wr(`OFS_MASTER, 8'h0A);
    cmp("flags", 8'h88, flags);
    // Unmapped offset and a foreign device address.
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    u_host.reg_write(DEV ^ 7'h01, `OFS_MASTER, 8'hFF, ok);
    cmp("foreign ack", 8'h00, {7'h00, ok});
    rd(`OFS_MASTER, 8'h0A);
    // Automatic shutdown clears the spare_store_bits bits.
    supply_below_in <= 1'b1;
    wr(`OFS_SUPPLY_MON, 8'h80);
    pause(8);
    cmp("flags", 8'hA0, flags);
    rd(`OFS_MASTER, 8'h00);
    rd(`OFS_SUPPLY_MON, 8'h90);
    // A second power-loss reset in mid-run.
    supply_below_in <= 1'b0;
    rst_in <= 1'b1;
    pause(3);
    rst_in <= 1'b0;
    pause(8);
    cmp("flags", 8'h00, flags);
    rd(`OFS_SUPPLY_MON, 8'h00);
    rd(`OFS_C1_CONTROL, 8'h00);
    close_out();
  end

endmodule : tb_pmu_system_and_conv1_regs
